//--- design/exc_ctrl_pkg.sv
// Constants and types of the state controller
package exc_ctrl_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int PSR_W = 16;

  // ==========================================================
  // Status word trace bits
  localparam int PSR_T_POS = 1;
  localparam int PSR_P_POS = 10;

  // ==========================================================
  // Frame layout; stack grows down
  localparam logic [ADDR_W-1:0] STACK_STEP = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] LINK_IP_OFFSET = 32'h0000_0008;
  localparam logic [ADDR_W-1:0] RESET_IP = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] RESET_WORD = 32'h0000_0000;
  localparam logic [PSR_W-1:0] RESET_PSR = 16'h0000;

  // ==========================================================
  // Operating states
  typedef enum logic [2:0] {
    ST_RESET, ST_EXECUTE, ST_EXCEPTION, ST_WAIT, ST_HALTED
  } op_state_type;

  // System interface status
  typedef enum logic [1:0] {
    STAT_RUN, STAT_WAIT, STAT_HALT, STAT_RESET
  } sys_status_type;

  // Exception sources
  typedef enum logic [3:0] {
    EXC_IRQ, EXC_NMI, EXC_DEBUG, EXC_TRAP_UNKNOWN, EXC_TRAP_FORBIDDEN,
    EXC_TRAP_OTHER, EXC_BREAKPOINT, EXC_BUS_RESTART, EXC_BUS_FATAL
  } exc_kind_type;

  // Instruction endings
  typedef enum logic [1:0] {
    END_COMPLETED, END_SUSPENDED, END_TERMINATED, END_PARTIAL
  } ending_type;

  // Exception sequence steps
  typedef enum logic [2:0] {
    SEQ_PUSH_PSR, SEQ_PUSH_IP, SEQ_PUSH_LINK, SEQ_READ_VECTOR, SEQ_READ_LINK_IP, SEQ_DONE
  } seq_step_type;

  // Instruction phases in logical order
  typedef enum logic [2:0] {
    PH_FETCH, PH_SOURCE, PH_COMPUTE, PH_RESULT, PH_FLAGS, PH_ADVANCE
  } phase_type;

endpackage

//--- design/ending_decode.sv
// Instruction ending and stacked status word
`timescale 1ns/1ps
`default_nettype none
module ending_decode
  import exc_ctrl_pkg::*;
(
  // Exception description
  input wire exc_kind_type kind,
  input wire logic mid_instr,
  input wire logic string_instr,
  // Status word and addresses
  input wire logic [PSR_W-1:0] psr_in,
  input wire logic [ADDR_W-1:0] cur_ip,
  input wire logic [ADDR_W-1:0] next_ip,
  // Decision
  output ending_type ending,
  output logic [PSR_W-1:0] psr_stacked,
  output logic [ADDR_W-1:0] ip_stacked
);

  // Ending selection by exception type
  always_comb begin
    ending = END_COMPLETED; // [RQ9]
    if (kind == EXC_BUS_FATAL) begin
      ending = END_TERMINATED; // [RQ15]
    end else if (mid_instr && string_instr &&
                 (kind == EXC_BUS_RESTART || kind == EXC_IRQ || kind == EXC_NMI || kind == EXC_DEBUG)) begin
      ending = END_PARTIAL; // [RQ16]
    end else if (mid_instr) begin
      ending = END_SUSPENDED; // [RQ8] [RQ10]
    end
  end

  // Trace-pending cleared for unknown-opcode, forbidden-op, bus errors and partial endings before the copy is stacked
  always_comb begin
    psr_stacked = psr_in;
    if (kind == EXC_TRAP_UNKNOWN || kind == EXC_TRAP_FORBIDDEN || kind == EXC_BUS_RESTART ||
        kind == EXC_BUS_FATAL || ending == END_PARTIAL) begin
      psr_stacked[PSR_P_POS] = 1'b0; // [RQ11] [RQ17]
    end
  end

  // Completed resumes after the instruction, others at its start
  always_comb begin
    ip_stacked = (ending == END_COMPLETED) ? next_ip : cur_ip; // [RQ9] [RQ10] [RQ13] [RQ17]
  end

endmodule
`default_nettype wire

//--- design/phase_tracker.sv
// Instruction phase order tracker
`timescale 1ns/1ps
`default_nettype none
module phase_tracker
  import exc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic clear,
  // Phase strobes
  input wire logic phase_valid,
  input wire phase_type phase_in,
  input wire logic ea_mem_read,
  // Results
  output phase_type phase_reg,
  output logic order_error_reg,
  output logic source_read
);

  // Address-calculation reads count as source reads
  assign source_read = (phase_valid && phase_in == PH_SOURCE) || ea_mem_read; // [RQ18]

  // Phase may only stay or move forward; advance wraps to fetch
  always_ff @(posedge clk) begin
    if (clear) begin
      phase_reg <= PH_FETCH;
      order_error_reg <= 1'b0;
    end else if (phase_valid) begin
      if (phase_in < phase_reg && phase_reg != PH_ADVANCE) begin
        order_error_reg <= 1'b1; // [RQ19]
      end
      phase_reg <= (phase_in == PH_ADVANCE) ? PH_FETCH : phase_in; // [RQ19]
    end
  end

endmodule
`default_nettype wire

//--- design/op_state_ctrl.sv
// Operating states and exception stacking
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RQ1: Reset input low forces reset state; release moves to executing.
// RQ2: Executing goes to exception on recognised exception, to waiting on wait instruction.
// RQ3: Exception pushes pointer, status word, linkage, then fetches new pointer and linkage; the code pushes the status word first, then the pointer.
// RQ4: Return to executing only after every exception data reference completes.
// RQ5: Waiting is idle with its own status; interrupt or debug starts exception.
// RQ6: Bus error during exception processing halts with its own status until reset.
// RQ7: Direct-exception mode skips linkage push and linkage read.
// RQ8: Mid-instruction exceptions end the instruction one of four ways by type.
// RQ9: Completed ending stacks the next instruction's address.
// RQ10: Suspended ending stacks the suspended instruction's address.
// RQ11: Unknown-opcode, forbidden-op and bus errors clear trace-pending before stacking.
// RQ12: Emulating software fixes stacked flags and pointer before trap return.
// RQ13: Trap return with unchanged stacked pointer re-executes the suspended instruction.
// RQ14: Software fixes stacked trace-pending after emulation or before re-execution.
// RQ15: Reset or fatal bus error terminates the instruction; not resumable.
// RQ16: String instruction interrupted by restartable error, interrupt or debug is partial.
// RQ17: Partial ending clears trace-pending and stacks that instruction's address.
// RQ18: Effective-address memory reads count as source-operand reads.
// RQ19: Instruction phases follow fetch, source, compute, result, flags, advance.
// RQ20: State is a five-value register; reset input beats every transition.
module op_state_ctrl
  import exc_ctrl_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_n,
  // Execution unit events
  input wire logic wait_instr,
  input wire logic direct_exc_mode,
  input wire logic trap_return,
  input wire logic [AW-1:0] return_ip,
  input wire logic [PSR_W-1:0] return_psr,
  // Exception request
  input wire logic exc_valid,
  input wire exc_kind_type exc_kind,
  input wire logic exc_mid_instr,
  input wire logic string_instr,
  input wire logic [AW-1:0] exc_vector_addr,
  // Pending sources seen while waiting
  input wire logic irq_pending,
  input wire logic debug_pending,
  // Processor context
  input wire logic [AW-1:0] cur_ip,
  input wire logic [AW-1:0] next_ip,
  input wire logic [PSR_W-1:0] processor_status_word,
  input wire logic [DW-1:0] linkage_base_register,
  input wire logic [AW-1:0] stack_ptr,
  // Instruction phase strobes
  input wire logic phase_valid,
  input wire phase_type phase_in,
  input wire logic ea_mem_read,
  // Data bus for exception references
  output logic bus_req,
  output logic bus_write,
  output logic [AW-1:0] bus_addr,
  output logic [DW-1:0] bus_wdata,
  input wire logic bus_done,
  input wire logic bus_error,
  input wire logic [DW-1:0] bus_rdata,
  // State and status
  output op_state_type state_reg,
  output sys_status_type sys_status,
  output logic exec_enable,
  // Exception results
  output logic exc_taken,
  output logic exc_done,
  output ending_type ending_reg,
  output logic resumable_reg,
  output logic [AW-1:0] new_ip_reg,
  output logic [DW-1:0] new_linkage_reg,
  output logic [AW-1:0] new_sp_reg,
  output logic [PSR_W-1:0] stacked_psr_reg,
  output logic [AW-1:0] stacked_ip_reg,
  // Instruction tracking
  output phase_type phase_reg,
  output logic phase_order_error,
  output logic source_read
);

  // ==========================================================
  // Helpers

  // Next stack slot below the given pointer
  function automatic logic [AW-1:0] push_addr(input logic [AW-1:0] sp);
    push_addr = sp - AW'(STACK_STEP);
  endfunction

  // Sources that wake the waiting state
  function automatic logic wake_source(input exc_kind_type k);
    wake_source = (k == EXC_IRQ) || (k == EXC_NMI) || (k == EXC_DEBUG);
  endfunction

  // ==========================================================
  // Declarations

  op_state_type state_next;
  seq_step_type step_reg;
  seq_step_type step_next;
  logic hold_reset;
  logic start_exc;
  logic ref_done;
  logic ref_error;
  ending_type ending_dec;
  logic [PSR_W-1:0] psr_dec;
  logic [AW-1:0] ip_dec;
  logic [AW-1:0] sp_reg;
  logic [AW-1:0] vector_reg;
  logic [DW-1:0] link_psr_word;

  // ==========================================================
  // Ending decision

  ending_decode u_ending (
    .kind(exc_kind),
    .mid_instr(exc_mid_instr),
    .string_instr(string_instr),
    .psr_in(processor_status_word),
    .cur_ip(cur_ip),
    .next_ip(next_ip),
    .ending(ending_dec),
    .psr_stacked(psr_dec),
    .ip_stacked(ip_dec)
  );

  // ==========================================================
  // Instruction phase order

  phase_tracker u_phase (
    .clk(clk),
    .clear(hold_reset),
    .phase_valid(phase_valid && state_reg == ST_EXECUTE),
    .phase_in(phase_in),
    .ea_mem_read(ea_mem_read),
    .phase_reg(phase_reg),
    .order_error_reg(phase_order_error),
    .source_read(source_read)
  );

  // ==========================================================
  // Operating state

  // Either reset forces the reset state
  assign hold_reset = srst || !reset_n; // [RQ1] [RQ20]

  // Exception accepted from executing, or a wake source while waiting
  assign start_exc = exc_valid &&
    ((state_reg == ST_EXECUTE) || (state_reg == ST_WAIT && wake_source(exc_kind))); // [RQ2] [RQ5]

  // Reference answer
  assign ref_done = bus_req && bus_done && !bus_error;
  assign ref_error = bus_req && bus_error;

  // Next-state decision
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: begin
        state_next = ST_EXECUTE; // [RQ1]
      end
      ST_EXECUTE: begin
        if (start_exc) begin
          state_next = ST_EXCEPTION; // [RQ2]
        end else if (wait_instr) begin
          state_next = ST_WAIT; // [RQ2]
        end
      end
      ST_WAIT: begin
        if (start_exc || irq_pending || debug_pending) begin
          state_next = ST_EXCEPTION; // [RQ5]
        end
      end
      ST_EXCEPTION: begin
        if (ref_error) begin
          state_next = ST_HALTED; // [RQ6]
        end else if (step_reg == SEQ_DONE) begin
          state_next = ST_EXECUTE; // [RQ4]
        end
      end
      ST_HALTED: begin
        state_next = ST_HALTED; // [RQ6]
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
  end

  // State register; reset wins
  always_ff @(posedge clk) begin
    if (hold_reset) begin
      state_reg <= ST_RESET; // [RQ1] [RQ20]
    end else begin
      state_reg <= state_next;
    end
  end

  // Interface status code
  always_comb begin
    case (state_reg)
      ST_WAIT: sys_status = STAT_WAIT; // [RQ5]
      ST_HALTED: sys_status = STAT_HALT; // [RQ6]
      ST_RESET: sys_status = STAT_RESET;
      default: sys_status = STAT_RUN;
    endcase
  end

  // Instructions run only while executing; waiting is idle
  assign exec_enable = (state_reg == ST_EXECUTE); // [RQ5]

  // ==========================================================
  // Exception reference sequence

  // Step order, skipping linkage in direct mode
  always_comb begin
    step_next = step_reg;
    case (step_reg)
      SEQ_PUSH_PSR: step_next = SEQ_PUSH_IP; // [RQ3]
      SEQ_PUSH_IP: step_next = direct_exc_mode ? SEQ_READ_VECTOR : SEQ_PUSH_LINK; // [RQ7]
      SEQ_PUSH_LINK: step_next = SEQ_READ_VECTOR; // [RQ3]
      SEQ_READ_VECTOR: step_next = direct_exc_mode ? SEQ_DONE : SEQ_READ_LINK_IP; // [RQ7]
      SEQ_READ_LINK_IP: step_next = SEQ_DONE; // [RQ3]
      default: step_next = SEQ_DONE;
    endcase
  end

  // Step advances as each reference completes
  always_ff @(posedge clk) begin
    if (hold_reset || state_reg != ST_EXCEPTION) begin
      step_reg <= SEQ_PUSH_PSR;
    end else if (ref_done) begin
      step_reg <= step_next; // [RQ4]
    end
  end

  // Status and linkage share one word slot each
  assign link_psr_word = DW'(stacked_psr_reg);

  // Registered bus request
  always_ff @(posedge clk) begin
    if (hold_reset) begin
      bus_req <= 1'b0;
      bus_write <= 1'b0;
      bus_addr <= RESET_WORD;
      bus_wdata <= RESET_WORD;
    end else if (state_reg == ST_EXCEPTION && step_reg != SEQ_DONE && !ref_error &&
                 !(ref_done && step_next == SEQ_DONE)) begin
      bus_req <= 1'b1;
      case (ref_done ? step_next : step_reg)
        SEQ_PUSH_PSR: begin
          bus_write <= 1'b1;
          bus_addr <= push_addr(sp_reg);
          bus_wdata <= link_psr_word; // [RQ3]
        end
        SEQ_PUSH_IP: begin
          bus_write <= 1'b1;
          bus_addr <= push_addr(push_addr(sp_reg));
          bus_wdata <= stacked_ip_reg; // [RQ3]
        end
        SEQ_PUSH_LINK: begin
          bus_write <= 1'b1;
          bus_addr <= push_addr(push_addr(push_addr(sp_reg)));
          bus_wdata <= linkage_base_register; // [RQ3]
        end
        SEQ_READ_VECTOR: begin
          bus_write <= 1'b0;
          bus_addr <= vector_reg; // [RQ3]
          bus_wdata <= RESET_WORD;
        end
        SEQ_READ_LINK_IP: begin
          bus_write <= 1'b0;
          bus_addr <= (ref_done ? AW'(bus_rdata) : AW'(new_linkage_reg)) + AW'(LINK_IP_OFFSET); // [RQ3]
          bus_wdata <= RESET_WORD;
        end
        default: begin
          bus_write <= 1'b0;
          bus_wdata <= RESET_WORD;
        end
      endcase
    end else begin
      bus_req <= 1'b0;
      bus_write <= 1'b0;
    end
  end

  // ==========================================================
  // Captured exception context

  // Frame contents latched at acceptance
  always_ff @(posedge clk) begin
    if (hold_reset) begin
      stacked_psr_reg <= RESET_PSR;
      stacked_ip_reg <= RESET_IP;
      sp_reg <= RESET_IP;
      vector_reg <= RESET_IP;
      ending_reg <= END_TERMINATED; // [RQ15]
      resumable_reg <= 1'b0; // [RQ15]
    end else if (start_exc) begin
      stacked_psr_reg <= psr_dec; // [RQ11] [RQ17]
      stacked_ip_reg <= ip_dec; // [RQ9] [RQ10] [RQ17]
      sp_reg <= stack_ptr;
      vector_reg <= exc_vector_addr;
      ending_reg <= ending_dec; // [RQ8]
      resumable_reg <= (ending_dec != END_TERMINATED); // [RQ15]
    end else if (state_reg == ST_WAIT && (irq_pending || debug_pending)) begin
      stacked_psr_reg <= processor_status_word; // [RQ9]
      stacked_ip_reg <= next_ip; // [RQ9]
      sp_reg <= stack_ptr;
      vector_reg <= exc_vector_addr;
      ending_reg <= END_COMPLETED;
      resumable_reg <= 1'b1;
    end
  end

  // New pointer and linkage
  always_ff @(posedge clk) begin
    if (hold_reset) begin
      new_ip_reg <= RESET_IP;
      new_linkage_reg <= RESET_WORD;
      new_sp_reg <= RESET_IP;
    end else if (trap_return && state_reg == ST_EXECUTE) begin
      new_ip_reg <= return_ip; // [RQ13]
      new_sp_reg <= new_sp_reg + AW'(direct_exc_mode ? 2 * STACK_STEP : 3 * STACK_STEP);
    end else if (ref_done) begin
      case (step_reg)
        SEQ_READ_VECTOR: begin
          if (direct_exc_mode) begin
            new_ip_reg <= bus_rdata; // [RQ7]
          end else begin
            new_linkage_reg <= bus_rdata; // [RQ3]
          end
        end
        SEQ_READ_LINK_IP: begin
          new_ip_reg <= bus_rdata; // [RQ3]
        end
        SEQ_PUSH_LINK, SEQ_PUSH_IP, SEQ_PUSH_PSR: begin
          new_sp_reg <= bus_addr;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Event pulses

  // Exception taken, and all of its references finished
  assign exc_taken = (state_reg != ST_EXCEPTION) && (state_next == ST_EXCEPTION) && !hold_reset;
  assign exc_done = (state_reg == ST_EXCEPTION) && (step_reg == SEQ_DONE) && !hold_reset; // [RQ4]

  // Return status word is not used here; software owns its trace bits
  logic unused_return_psr;
  assign unused_return_psr = ^return_psr;

endmodule
`default_nettype wire

//--- design/unused_placeholder_none.sv
// Holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- sim/op_state_assertions.sv
// Checks on the state controller ports
`timescale 1ns/1ps
`default_nettype none
module op_state_checker
  import exc_ctrl_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_n,
  // Controller inputs
  input wire logic wait_instr,
  input wire logic exc_valid,
  input wire logic irq_pending,
  input wire logic debug_pending,
  input wire logic ea_mem_read,
  input wire logic bus_done,
  input wire logic bus_error,
  // Controller outputs
  input wire logic bus_req,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire op_state_type state_reg,
  input wire sys_status_type sys_status,
  input wire logic exc_taken,
  input wire logic exc_done,
  input wire logic source_read
);
  // ========
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !reset_n);

  chk_reset_enter: assert property (disable iff (1'b0) (srst || !reset_n) |=> state_reg == ST_RESET)
    else $error("reset not entered");
  chk_reset_leave: assert property (state_reg == ST_RESET |=> state_reg == ST_EXECUTE)
    else $error("reset not left");
  chk_exc_accept: assert property (state_reg == ST_EXECUTE && exc_valid |-> exc_taken ##1 state_reg == ST_EXCEPTION)
    else $error("exception not taken");
  chk_wait_enter: assert property (state_reg == ST_EXECUTE && wait_instr && !exc_valid |=> state_reg == ST_WAIT)
    else $error("wait not entered");
  chk_wait_idle: assert property (state_reg == ST_WAIT |-> sys_status == STAT_WAIT && !bus_req)
    else $error("waiting not idle");
  chk_wait_wake: assert property (state_reg == ST_WAIT && (irq_pending || debug_pending) |=> state_reg == ST_EXCEPTION)
    else $error("wake missed");
  chk_error_halt: assert property (state_reg == ST_EXCEPTION && bus_req && bus_error |=> state_reg == ST_HALTED && !bus_req)
    else $error("no halt on bus error");
  chk_halt_stays: assert property (state_reg == ST_HALTED |-> sys_status == STAT_HALT ##1 state_reg == ST_HALTED)
    else $error("halt not kept");
  chk_done_return: assert property (exc_done |-> !bus_req ##1 state_reg == ST_EXECUTE)
    else $error("no return to executing");
  chk_req_hold: assert property (bus_req && !bus_done && !bus_error |=> bus_req && $stable(bus_addr))
    else $error("request not held");
  chk_ea_source: assert property (ea_mem_read |-> source_read)
    else $error("address read not a source read");

  // Main scenarios reached
  cov_wake: cover property (state_reg == ST_WAIT ##1 state_reg == ST_EXCEPTION);
  cov_halt: cover property (state_reg == ST_HALTED);
  cov_done: cover property (exc_done);
endmodule
`default_nettype wire

//--- sim/bus_partner.sv
// System bus model
`timescale 1ns/1ps
`default_nettype none
module bus_partner
  import exc_ctrl_pkg::*;
(
  // Clock
  input wire logic clk,
  // Request from the controller
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  // Answer delay and failing reference index
  input wire logic [7:0] wait_cycles,
  input wire logic [7:0] fail_ref,
  // Answer
  output logic bus_done,
  output logic bus_error,
  output logic [DATA_W-1:0] bus_rdata
);
  int cnt = 0;
  int refs = 0;
  logic [ADDR_W-1:0] log_addr [0:127];
  logic [DATA_W-1:0] log_data [0:127];

  // ========
  // One reference at a time; read data is valid only with done
  initial begin
    bus_done = 1'b0;
    bus_error = 1'b0;
    bus_rdata = 32'h0000_0000;
  end
  always @(posedge clk) begin
    if (bus_done || bus_error) begin
      log_addr[refs] <= bus_addr;
      log_data[refs] <= bus_write ? bus_wdata : bus_rdata;
      refs <= refs + 1;
      cnt <= 0;
      bus_done <= 1'b0;
      bus_error <= 1'b0;
      bus_rdata <= ~bus_rdata; // Stale data is scrambled
    end else if (bus_req && cnt >= int'(wait_cycles)) begin
      bus_error <= (refs[7:0] == fail_ref);
      bus_done <= (refs[7:0] != fail_ref);
      bus_rdata <= bus_addr + 32'h0000_1000;
    end else begin
      cnt <= cnt + (bus_req ? 1 : 0);
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Bench for the state controller
`timescale 1ns/1ps
`default_nettype none
module testbench
  import exc_ctrl_pkg::*;
;
  logic clk = 0, srst = 1, reset_n = 1, wait_instr = 0, direct_exc_mode = 0, trap_return = 0, exc_valid = 0;
  logic exc_mid_instr = 0, string_instr = 0, irq_pending = 0, debug_pending = 0, phase_valid = 0, ea_mem_read = 0;
  logic [31:0] cur_ip = 32'h0000_2000, next_ip = 32'h0000_2004, stack_ptr = 32'h0000_8000, return_ip = 32'h0;
  logic [31:0] exc_vector_addr = 32'h0000_0100, linkage_base_register = 32'h0000_3000;
  logic [15:0] processor_status_word = 16'h0402, return_psr = 16'h0000;
  logic [7:0] wait_cycles = 8'h00, fail_ref = 8'hff;
  exc_kind_type exc_kind = EXC_IRQ;
  phase_type phase_in = PH_FETCH;
  logic bus_done, bus_error, bus_req, bus_write, exec_enable, exc_taken, exc_done, resumable_reg;
  logic phase_order_error, source_read;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, new_ip_reg, stacked_ip_reg, new_sp_reg;
  logic [15:0] stacked_psr_reg;
  phase_type phase_reg;
  op_state_type state_reg;
  sys_status_type sys_status;
  ending_type ending_reg;
  int num_errors = 0;
  int checked = 0;

  // ========
  // Design, partner, clock
  op_state_ctrl i_dut (.clk, .srst, .reset_n, .wait_instr, .direct_exc_mode, .trap_return, .return_ip, .return_psr,
    .exc_valid, .exc_kind, .exc_mid_instr, .string_instr, .exc_vector_addr, .irq_pending, .debug_pending, .cur_ip,
    .next_ip, .processor_status_word, .linkage_base_register, .stack_ptr, .phase_valid, .phase_in, .ea_mem_read,
    .bus_req, .bus_write, .bus_addr, .bus_wdata, .bus_done, .bus_error, .bus_rdata, .state_reg, .sys_status,
    .exec_enable, .exc_taken, .exc_done, .ending_reg, .resumable_reg, .new_ip_reg, .new_linkage_reg(),
    .new_sp_reg, .stacked_psr_reg, .stacked_ip_reg, .phase_reg, .phase_order_error, .source_read);
  bus_partner i_bus (.clk, .bus_req, .bus_write, .bus_addr, .bus_wdata, .wait_cycles, .fail_ref, .bus_done,
    .bus_error, .bus_rdata);
  always #10 clk = ~clk;

  // ========
  // Shared tasks
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tick();
    @(negedge clk);
  endtask
  task automatic wait_done();
    for (int n = 0; n < 100 && exc_done !== 1'b1; n++) tick();
    if (exc_done !== 1'b1) begin
      check("exc_done", exc_done, 1);
      stop_test();
    end
  endtask

  // ========
  // Scenarios
  task automatic t_phase();
    phase_valid = 1;
    for (int i = 0; i < 7; i++) begin
      phase_in = (i == 6) ? PH_SOURCE : phase_type'(i);
      tick();
    end
    check("order ok", phase_order_error, 0);
    phase_in = PH_FETCH;
    tick();
    phase_valid = 0;
    ea_mem_read = 1;
    #1 check("ea source", source_read, 1);
    check("order bad", phase_order_error, 1);
    tick();
    ea_mem_read = 0;
    $display("test phase done");
  endtask
  task automatic t_return();
    return_psr = processor_status_word & ~(16'h0001 << PSR_P_POS);
    for (int i = 0; i < 2; i++) begin
      return_ip = i ? next_ip : cur_ip;
      trap_return = 1;
      tick();
      trap_return = 0;
      check("return ip", new_ip_reg, return_ip);
      tick();
    end
    $display("test return done");
  endtask
  task automatic do_exc(exc_kind_type k, logic mid, logic str, logic dir, ending_type e, logic clr);
    int b;
    logic [15:0] psw;
    b = i_bus.refs;
    psw = clr ? processor_status_word & ~(16'h0001 << PSR_P_POS) : processor_status_word;
    wait_cycles = 8'(b % 3);
    direct_exc_mode = dir;
    exc_kind = k;
    exc_mid_instr = mid;
    string_instr = str;
    exc_valid = 1;
    #1 check("exc_taken", exc_taken, 1);
    tick();
    exc_valid = 0;
    check("exc state", state_reg, ST_EXCEPTION);
    wait_done();
    tick();
    check("back to run", state_reg, ST_EXECUTE);
    check("ending", ending_reg, e);
    check("resumable", resumable_reg, e != END_TERMINATED);
    check("psr push addr", i_bus.log_addr[b], stack_ptr - 4);
    check("psr push", i_bus.log_data[b], {16'h0000, psw});
    check("stacked psr", stacked_psr_reg, psw);
    check("ip push addr", i_bus.log_addr[b + 1], stack_ptr - 8);
    if (e != END_TERMINATED) begin
      check("ip push", i_bus.log_data[b + 1], (e == END_COMPLETED) ? next_ip : cur_ip);
      check("stacked ip", stacked_ip_reg, (e == END_COMPLETED) ? next_ip : cur_ip);
    end
    if (!dir) check("link push", i_bus.log_data[b + 2], linkage_base_register);
    check("vector read", i_bus.log_addr[b + (dir ? 2 : 3)], exc_vector_addr);
    check("ref count", 32'(i_bus.refs - b), dir ? 3 : 5);
    check("new sp", new_sp_reg, stack_ptr - (dir ? 8 : 12));
    check("new ip", new_ip_reg, exc_vector_addr + (dir ? 32'h1000 : 32'h2008));
    $display("test exception %s done", k.name());
  endtask
  task automatic t_wait();
    int b;
    for (int w = 0; w < 2; w++) begin
      wait_instr = 1;
      tick();
      wait_instr = 0;
      b = i_bus.refs;
      check("wait state", state_reg, ST_WAIT);
      repeat (3) tick();
      check("wait status", sys_status, STAT_WAIT);
      check("wait idle", 32'(i_bus.refs - b), 0);
      irq_pending = (w == 0);
      debug_pending = (w == 1);
      tick();
      irq_pending = 0;
      debug_pending = 0;
      check("wake state", state_reg, ST_EXCEPTION);
      wait_done();
      check("wake ending", ending_reg, END_COMPLETED);
      check("wake ip push", i_bus.log_data[b + 1], next_ip);
      tick();
    end
    $display("test wait done");
  endtask
  task automatic t_halt();
    fail_ref = 8'(i_bus.refs + 1);
    exc_kind = EXC_IRQ;
    exc_valid = 1;
    for (int n = 0; n < 50 && state_reg !== ST_HALTED; n++) tick();
    check("halt state", state_reg, ST_HALTED);
    repeat (5) tick();
    check("still halted", state_reg, ST_HALTED);
    check("halt status", sys_status, STAT_HALT);
    check("halt bus", bus_req, 0);
    reset_n = 0;
    tick();
    check("reset beats halt", state_reg, ST_RESET);
    check("reset status", sys_status, STAT_RESET);
    reset_n = 1;
    exc_valid = 0;
    fail_ref = 8'hff;
    tick();
    check("run again", state_reg, ST_EXECUTE);
    $display("test halt done");
  endtask

  // ========
  // Main sequence
  initial begin
    repeat (10) tick();
    check("reset state", state_reg, ST_RESET);
    srst = 0;
    tick();
    check("run state", state_reg, ST_EXECUTE);
    check("run enable", exec_enable, 1);
    t_phase();
    t_return();
    do_exc(EXC_IRQ, 0, 0, 0, END_COMPLETED, 0);
    do_exc(EXC_TRAP_UNKNOWN, 1, 0, 0, END_SUSPENDED, 1);
    do_exc(EXC_TRAP_FORBIDDEN, 1, 0, 1, END_SUSPENDED, 1);
    do_exc(EXC_BREAKPOINT, 1, 0, 0, END_SUSPENDED, 0);
    do_exc(EXC_TRAP_OTHER, 1, 0, 1, END_SUSPENDED, 0);
    do_exc(EXC_BUS_RESTART, 1, 1, 0, END_PARTIAL, 1);
    do_exc(EXC_DEBUG, 1, 1, 1, END_PARTIAL, 1);
    do_exc(EXC_NMI, 1, 1, 0, END_PARTIAL, 1);
    do_exc(EXC_BUS_FATAL, 1, 0, 0, END_TERMINATED, 1);
    t_wait();
    t_halt();
    stop_test();
  end
endmodule

// Checker on the controller
bind op_state_ctrl op_state_checker i_chk (.clk, .srst, .reset_n, .wait_instr, .exc_valid, .irq_pending,
  .debug_pending, .ea_mem_read, .bus_done, .bus_error, .bus_req, .bus_addr, .state_reg, .sys_status, .exc_taken,
  .exc_done, .source_read);
`default_nettype wire
